// File: ssp_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port
// Assumes: One system clock; all configuration arrives as plain ports
// Notes:   Format codes, interrupt bit positions and thresholds live here

package ssp_pkg;

	// ----------------------------------------------------------------
	// Data and queue shape
	// ----------------------------------------------------------------
	localparam int          DATA_W        = 16;
	localparam int          QUEUE_DEPTH   = 8;
	localparam int          CNT_W         = 4;
	localparam logic [3:0]  QUEUE_HALF    = 4'h4;  // Service threshold
	localparam logic [4:0]  CMD_BITS      = 5'h08; // Control message length
	localparam logic [4:0]  TURN_BITS     = 5'h01; // Turnaround clock after it
	localparam logic [4:0]  SIZE_MIN      = 5'h04;

	// ----------------------------------------------------------------
	// Divider limits and timeout
	// ----------------------------------------------------------------
	localparam logic [7:0]  PRESCALE_MIN  = 8'h02;
	localparam logic [7:0]  PRESCALE_MAX  = 8'hfe;
	localparam logic [6:0]  TIMEOUT_HALVES = 7'h40; // 32 serial clock periods

	// ----------------------------------------------------------------
	// Interrupt source positions
	// ----------------------------------------------------------------
	localparam int          INT_TX_SVC    = 0;
	localparam int          INT_RX_SVC    = 1;
	localparam int          INT_RX_TMO    = 2;
	localparam int          INT_RX_OVR    = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0]  EDGE_RST      = 6'h00;
	localparam logic [15:0] WORD_RST      = 16'h0000;

	// Frame formats
	typedef enum logic [1:0] {
		FMT_SPI   = 2'b00,
		FMT_PULSE = 2'b01,
		FMT_HALF  = 2'b10,
		FMT_RSVD  = 2'b11
	} ssp_fmt_e;

	// Frame sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b10,
		ST_TAIL  = 2'b11
	} ssp_state_e;

	// Link configuration carried as one group
	typedef struct packed {
		ssp_fmt_e    frame_format;
		logic        clock_polarity;
		logic        clock_phase;
		logic [3:0]  data_size;         // Word length minus one, 3..15
		logic [7:0]  prescale_divisor;  // Even, 2..254
		logic [7:0]  serial_clock_rate; // Second divisor minus one
	} ssp_cfg_s;

endpackage

// File: ssp_top.sv
// Purpose: Master synchronous serial port with queues, DMA requests, interrupts
// Assumes: Pins synchronous to clk; master operation; config steady in a frame
// Notes:   Serial clock derived from clk through two dividers into half ticks
//
// What this block does
// - System clock first divided by an even prescale divisor, 2 to 254.
// - Then divided by one plus rate field; serial clock is product quotient.
// - Transmit words wait in a 16-bit, 8-entry queue until serialized.
// - Received words wait in a 16-bit, 8-entry queue until read.
// - Writing the data port pushes the word into the transmit queue.
// - Reading the data port pops the oldest received word.
// - Both queues raise DMA requests only when their enable bits are set.
// - Four interrupt sources are ORed into one interrupt request line.
// - A source reaches the request only when its mask bit is one.
// - Raw and masked status of every source are both readable.
// - Words are 4 to 16 bits, most significant bit first.
// - Serial clock rests at its idle level, toggling only during frames.
// - Idle serial clock for a timeout with received data raises timeout.
// - In SPI and half-duplex formats frame select is low all frame.
// - Frame-pulse format launches on rising edges, samples on falling edges.
// - Frame-pulse idle: clock and frame low, transmit line released.
// - Frame-pulse: one-period frame pulse, word loaded, MSB on next rise.
// - Frame-pulse: received word queued on first rise after its LSB.
// - Half-duplex: 8-bit command without receive, then 4-16 bit reply.
// - SPI clock polarity bit sets the idle clock level.
// - SPI phase bit selects first or second transition for sampling.

`timescale 1ns/1ps

// ----------------------------------------------------------------
// Generic queue
// ----------------------------------------------------------------
module ssp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	// Handshakes and status
	assign in_ready  = (count_r != CW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r];
	assign count     = count_r;

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // ssp_fifo

// ----------------------------------------------------------------
// Serial port top
// ----------------------------------------------------------------
module ssp_top #(
	parameter int DATA_W = ssp_pkg::DATA_W,
	parameter int DEPTH  = ssp_pkg::QUEUE_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              port_enable,
	input  wire ssp_pkg::ssp_cfg_s cfg,
	input  wire logic              tx_wr_valid,
	output logic                   tx_wr_ready,
	input  wire logic [DATA_W-1:0] tx_wr_data,
	output logic                   rx_rd_valid,
	input  wire logic              rx_rd_ready,
	output logic [DATA_W-1:0]      rx_rd_data,
	input  wire logic              dma_tx_enable,
	input  wire logic              dma_rx_enable,
	output logic                   dma_tx_req,
	output logic                   dma_rx_req,
	input  wire logic [3:0]        interrupt_mask,
	input  wire logic              clear_timeout,
	input  wire logic              clear_overrun,
	output logic [3:0]             raw_int_status,
	output logic [3:0]             masked_int_status,
	output logic                   int_req,
	output logic                   serial_clock_pin_o,
	output logic                   serial_clock_pin_oe_n,
	output logic                   frame_select_pin,
	output logic                   serial_out_pin_o,
	output logic                   serial_out_pin_oe_n,
	input  wire logic              serial_in_pin
);
	localparam int CW = $clog2(DEPTH+1);

	ssp_pkg::ssp_state_e state_r;
	ssp_pkg::ssp_fmt_e   fmt_r;
	logic                cpol_r;
	logic                cpha_r;
	logic [4:0]          nsize_r;
	logic [6:0]          pre_cnt_r;
	logic [7:0]          scr_cnt_r;
	logic [5:0]          edge_r;
	logic                tail_r;
	logic [15:0]         tx_sh_r;
	logic [15:0]         rx_sh_r;
	logic                rx_push_r;
	logic [15:0]         rx_word_r;
	logic [6:0]          tmo_cnt_r;
	logic                tmo_r;
	logic                ovr_r;
	logic                sclk_r;
	logic                fss_r;
	logic                sout_r;
	logic                sout_oe_n_r;
	logic                sclk_oe_n_r;
	logic [3:0]          raw_r;
	logic [3:0]          masked_r;
	logic                int_r;
	logic                dma_tx_r;
	logic                dma_rx_r;

	logic                tx_q_valid;
	logic [DATA_W-1:0]   tx_q_data;
	logic [CW-1:0]       tx_count;
	logic                rx_in_ready;
	logic [CW-1:0]       rx_count;

	// ----------------------------------------------------------------
	// Bit rate dividers
	// ----------------------------------------------------------------
	// Half a serial period is prescale/2 times (1 + rate) system cycles
	logic [6:0] pre_half;
	logic       pre_tick;
	logic       half_tick;
	assign pre_half  = (cfg.prescale_divisor[7:1] == 7'h00) ? 7'h01
	                   : cfg.prescale_divisor[7:1];
	assign pre_tick  = (pre_cnt_r >= pre_half - 7'h01);
	assign half_tick = pre_tick && (scr_cnt_r >= cfg.serial_clock_rate);

	// Free running divider chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_cnt_r <= 7'h00;
			scr_cnt_r <= 8'h00;
		end else begin
			pre_cnt_r <= pre_tick ? 7'h00 : pre_cnt_r + 7'h01;
			if (pre_tick) begin
				scr_cnt_r <= half_tick ? 8'h00 : scr_cnt_r + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	logic start;
	assign start = half_tick && (state_r == ssp_pkg::ST_IDLE) && port_enable && tx_q_valid;

	// Transmit queue, written by the data port, drained at frame start
	ssp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_q (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (tx_wr_valid),
		.in_ready  (tx_wr_ready),
		.in_data   (tx_wr_data),
		.out_valid (tx_q_valid),
		.out_ready (start),
		.out_data  (tx_q_data),
		.count     (tx_count)
	);

	// Receive queue, filled by the shifter, drained by the data port
	ssp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_q (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (rx_push_r),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word_r),
		.out_valid (rx_rd_valid),
		.out_ready (rx_rd_ready),
		.out_data  (rx_rd_data),
		.count     (rx_count)
	);

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// Word length, bits per frame and edge parity
	logic [4:0]  n_in;
	logic [4:0]  nbits;
	logic [5:0]  last_edge;
	logic        is_pulse;
	logic        is_half;
	logic        cpha_eff;
	logic        cpol_eff;
	logic        sample_now;
	logic        shift_now;
	logic [15:0] load_word;
	logic [15:0] rx_mask;
	assign n_in       = {1'b0, cfg.data_size} + 5'h01;
	assign is_pulse   = (fmt_r == ssp_pkg::FMT_PULSE);
	assign is_half    = (fmt_r == ssp_pkg::FMT_HALF);
	assign nbits      = is_half ? nsize_r + ssp_pkg::CMD_BITS + ssp_pkg::TURN_BITS
	                            : nsize_r;
	assign last_edge  = {nbits, 1'b0} - 6'h01;
	assign cpha_eff   = is_pulse ? 1'b1 : (is_half ? 1'b0 : cpha_r);
	assign cpol_eff   = (fmt_r == ssp_pkg::FMT_SPI || fmt_r == ssp_pkg::FMT_RSVD)
	                    ? cpol_r : 1'b0;
	assign sample_now = (edge_r[0] == cpha_eff) &&
	                    (!is_half || edge_r[5:1] >= ssp_pkg::CMD_BITS + ssp_pkg::TURN_BITS);
	assign shift_now  = (edge_r[0] != cpha_eff) && (edge_r != 6'h00) && (edge_r != last_edge);
	assign load_word  = (cfg.frame_format == ssp_pkg::FMT_HALF) ? {tx_q_data[7:0], 8'h00}
	                    : 16'(tx_q_data << (5'h10 - n_in));
	assign rx_mask    = 16'(17'h0ffff >> (5'h10 - nsize_r));

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	// Config latched at start; all moves on half ticks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ssp_pkg::ST_IDLE;
			fmt_r   <= ssp_pkg::FMT_SPI;
			cpol_r  <= 1'b0;
			cpha_r  <= 1'b0;
			nsize_r <= ssp_pkg::SIZE_MIN;
			edge_r  <= ssp_pkg::EDGE_RST;
			tail_r  <= 1'b0;
		end else if (half_tick) begin
			case (state_r)
				ssp_pkg::ST_IDLE: begin
					if (start) begin
						fmt_r   <= cfg.frame_format;
						cpol_r  <= cfg.clock_polarity;
						cpha_r  <= cfg.clock_phase;
						nsize_r <= n_in;
						state_r <= ssp_pkg::ST_LEAD;
					end
				end
				ssp_pkg::ST_LEAD: begin
					// One half period, so a frame pulse spans one serial period
					edge_r  <= ssp_pkg::EDGE_RST;
					state_r <= ssp_pkg::ST_SHIFT;
				end
				ssp_pkg::ST_SHIFT: begin
					edge_r <= edge_r + 6'h01;
					if (edge_r == last_edge) begin
						tail_r  <= 1'b0;
						state_r <= ssp_pkg::ST_TAIL;
					end
				end
				ssp_pkg::ST_TAIL: begin
					tail_r <= 1'b1;
					if (tail_r) begin
						state_r <= ssp_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= ssp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Shift registers: transmit leftward, receive into the low end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_sh_r <= ssp_pkg::WORD_RST;
			rx_sh_r <= ssp_pkg::WORD_RST;
		end else if (start) begin
			tx_sh_r <= load_word;
		end else if (half_tick && state_r == ssp_pkg::ST_SHIFT) begin
			if (shift_now) begin
				tx_sh_r <= {tx_sh_r[14:0], 1'b0};
			end
			if (sample_now) begin
				rx_sh_r <= {rx_sh_r[14:0], serial_in_pin};
			end
		end
	end

	// Received word handed to the queue on the first tail tick
	logic tail_push;
	assign tail_push = half_tick && (state_r == ssp_pkg::ST_TAIL) && !tail_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_push_r <= 1'b0;
			rx_word_r <= ssp_pkg::WORD_RST;
		end else begin
			rx_push_r <= tail_push;
			if (tail_push) begin
				rx_word_r <= rx_sh_r & rx_mask;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Next pin levels per state and format
	logic idle_fss;
	logic sclk_nxt;
	logic fss_nxt;
	logic sout_nxt;
	logic oe_n_nxt;
	assign idle_fss = (cfg.frame_format != ssp_pkg::FMT_PULSE);

	always_comb begin
		sclk_nxt = sclk_r;
		fss_nxt  = fss_r;
		sout_nxt = sout_r;
		oe_n_nxt = sout_oe_n_r;
		case (state_r)
			ssp_pkg::ST_IDLE: begin
				if (start) begin
					sclk_nxt = (cfg.frame_format == ssp_pkg::FMT_PULSE);
					fss_nxt  = (cfg.frame_format == ssp_pkg::FMT_PULSE);
					sout_nxt = (cfg.frame_format == ssp_pkg::FMT_PULSE) ? 1'b0 : load_word[15];
					oe_n_nxt = (cfg.frame_format == ssp_pkg::FMT_PULSE);
				end else begin
					sclk_nxt = (cfg.frame_format == ssp_pkg::FMT_SPI ||
					            cfg.frame_format == ssp_pkg::FMT_RSVD) ?
					           cfg.clock_polarity : 1'b0;
					fss_nxt  = idle_fss;
					sout_nxt = 1'b0;
					oe_n_nxt = !idle_fss;
				end
			end
			ssp_pkg::ST_LEAD: begin
				sclk_nxt = is_pulse ? 1'b0 : cpol_eff;
			end
			ssp_pkg::ST_SHIFT: begin
				sclk_nxt = !sclk_r;
				if (edge_r == 6'h00 && cpha_eff) begin
					sout_nxt = tx_sh_r[15];
					oe_n_nxt = 1'b0;
					fss_nxt  = is_pulse ? 1'b0 : fss_r;
				end else if (shift_now) begin
					sout_nxt = tx_sh_r[14];
				end
			end
			ssp_pkg::ST_TAIL: begin
				sclk_nxt = is_pulse ? !tail_r : cpol_eff;
				fss_nxt  = is_pulse ? 1'b0 : tail_r;
				oe_n_nxt = is_pulse ? tail_r : 1'b0;
			end
			default: begin
				sclk_nxt = 1'b0;
			end
		endcase
	end

	// Registered pin outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_r      <= 1'b0;
			fss_r       <= 1'b1;
			sout_r      <= 1'b0;
			sout_oe_n_r <= 1'b0;
			sclk_oe_n_r <= 1'b1;
		end else begin
			sclk_oe_n_r <= !port_enable;
			if (half_tick) begin
				sclk_r      <= sclk_nxt;
				fss_r       <= fss_nxt;
				sout_r      <= sout_nxt;
				sout_oe_n_r <= oe_n_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Timeout, overrun and interrupt status
	// ----------------------------------------------------------------
	// Idle half ticks counted while received data waits
	logic tmo_arm;
	logic tmo_hit;
	logic ovr_hit;
	assign tmo_arm = (state_r == ssp_pkg::ST_IDLE) && rx_rd_valid;
	assign tmo_hit = tmo_arm && half_tick && (tmo_cnt_r == ssp_pkg::TIMEOUT_HALVES - 7'h01);
	assign ovr_hit = rx_push_r && !rx_in_ready;

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmo_cnt_r <= 7'h00;
			tmo_r     <= 1'b0;
			ovr_r     <= 1'b0;
		end else begin
			if (!tmo_arm) begin
				tmo_cnt_r <= 7'h00;
			end else if (half_tick && tmo_cnt_r != ssp_pkg::TIMEOUT_HALVES) begin
				tmo_cnt_r <= tmo_cnt_r + 7'h01;
			end
			tmo_r <= tmo_hit | (tmo_r & !clear_timeout);
			ovr_r <= ovr_hit | (ovr_r & !clear_overrun);
		end
	end

	// Raw sources, masking, combined request and DMA requests
	logic [3:0] raw_nxt;
	assign raw_nxt[ssp_pkg::INT_TX_SVC] = (tx_count <= CW'(ssp_pkg::QUEUE_HALF));
	assign raw_nxt[ssp_pkg::INT_RX_SVC] = (rx_count >= CW'(ssp_pkg::QUEUE_HALF));
	assign raw_nxt[ssp_pkg::INT_RX_TMO] = tmo_hit | tmo_r;
	assign raw_nxt[ssp_pkg::INT_RX_OVR] = ovr_hit | ovr_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raw_r    <= 4'h0;
			masked_r <= 4'h0;
			int_r    <= 1'b0;
			dma_tx_r <= 1'b0;
			dma_rx_r <= 1'b0;
		end else begin
			raw_r    <= raw_nxt;
			masked_r <= raw_nxt & interrupt_mask;
			int_r    <= |(raw_nxt & interrupt_mask);
			dma_tx_r <= dma_tx_enable && (tx_count != CW'(DEPTH));
			dma_rx_r <= dma_rx_enable && (rx_count != '0);
		end
	end

	// Output wiring
	assign raw_int_status        = raw_r;
	assign masked_int_status     = masked_r;
	assign int_req               = int_r;
	assign dma_tx_req            = dma_tx_r;
	assign dma_rx_req            = dma_rx_r;
	assign serial_clock_pin_o    = sclk_r;
	assign serial_clock_pin_oe_n = sclk_oe_n_r;
	assign frame_select_pin      = fss_r;
	assign serial_out_pin_o      = sout_r;
	assign serial_out_pin_oe_n   = sout_oe_n_r;
endmodule // ssp_top

// File: ssp_top_monitor.sv
// Purpose: Port assertions for ssp_top
// Assumes: cfg steady within frames
// Notes:   Frame timing checks apply to a one clk half tick
`timescale 1ns/1ps
// ------------------------------
// Checker
// ------------------------------
module ssp_top_monitor #(
	parameter int DATA_W = 16
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire ssp_pkg::ssp_cfg_s cfg,
	input wire logic              tx_wr_ready,
	input wire logic              rx_rd_valid,
	input wire logic [DATA_W-1:0] rx_rd_data,
	input wire logic              dma_tx_enable,
	input wire logic              dma_rx_enable,
	input wire logic              dma_tx_req,
	input wire logic              dma_rx_req,
	input wire logic [3:0]        interrupt_mask,
	input wire logic [3:0]        raw_int_status,
	input wire logic [3:0]        masked_int_status,
	input wire logic              int_req,
	input wire logic              serial_clock_pin_o,
	input wire logic              frame_select_pin
);
	logic h1;
	logic spi;
	// Fastest divider setting and format decode
	assign h1  = cfg.prescale_divisor == 8'h02 && cfg.serial_clock_rate == 8'h00;
	assign spi = cfg.frame_format == ssp_pkg::FMT_SPI;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_masked_and: assert property (
		($stable(raw_int_status) && $stable(interrupt_mask)) [*3]
		|-> masked_int_status == (raw_int_status & interrupt_mask)) else $error("masked status");
	a_int_or: assert property (
		$stable(masked_int_status) [*2] |-> int_req == |masked_int_status) else $error("int_req");
	a_dma_tx_gate: assert property (
		dma_tx_req == $past(dma_tx_enable && tx_wr_ready)) else $error("dma tx request");
	a_dma_rx_gate: assert property (
		dma_rx_req == $past(dma_rx_enable && rx_rd_valid)) else $error("dma rx request");
	a_clock_quiet: assert property (
		$changed(serial_clock_pin_o) && spi && cfg == $past(cfg, 8)
		|-> !frame_select_pin || !$past(frame_select_pin)) else $error("clock outside frame");
	a_spi_select: assert property (
		$fell(frame_select_pin) && h1 && spi && cfg.data_size == 4'h7
		|-> (!frame_select_pin) [*8] ##1 (!frame_select_pin) [*8]) else $error("select rose");
	a_pulse_width: assert property (
		$rose(frame_select_pin) && h1 && cfg.frame_format == ssp_pkg::FMT_PULSE
		|-> frame_select_pin [*2] ##1 !frame_select_pin) else $error("frame pulse width");
	a_timeout_cause: assert property (
		$rose(raw_int_status[ssp_pkg::INT_RX_TMO])
		|-> $past(rx_rd_valid) || $past(rx_rd_valid, 2)) else $error("timeout when empty");
	a_size_upper: assert property (
		rx_rd_valid && cfg.data_size == 4'h7 && $stable(cfg)
		|-> rx_rd_data[DATA_W-1:8] == 8'h00) else $error("upper bits set");
endmodule // ssp_top_monitor

bind ssp_top ssp_top_monitor #(.DATA_W(DATA_W)) i_ssp_top_monitor (.*);

// File: ssp_slave_model.sv
// Purpose: Off-chip serial slave answering every frame with one byte
// Assumes: SPI mode 0 or frame-pulse format, eight bit words
// Notes:   Line shows inverse of last bit while deselected
`timescale 1ns/1ps
module ssp_slave_model (
	input  wire logic       clk,
	input  wire logic       sclk,
	input  wire logic       fss,
	input  wire logic       mosi,
	input  wire logic       pulse,
	input  wire logic [7:0] reply,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh_r;
	logic       first_r;
	logic       last_r = 1'b0;
	logic       sclk_q = 1'b0;
	// No stale bit on a released line
	assign miso = fss ? ~last_r : sh_r[7];
	// Pins looked at mid-cycle, clear of the edge that moves them
	always @(negedge clk) begin
		sclk_q <= sclk;
		if (fss) begin
			sh_r    <= reply;
			first_r <= 1'b1;
		end else if (sclk != sclk_q && sclk == pulse) begin
			if (!(pulse && first_r))
				sh_r <= {sh_r[6:0], 1'b0};
			first_r <= 1'b0;
		end else if (sclk != sclk_q) begin
			got <= {got[6:0], mosi};
		end
	end
	// Remember the bit last driven
	always @(posedge clk)
		if (!fss)
			last_r <= sh_r[7];
endmodule // ssp_slave_model

// File: tb_sync_serial_port.sv
// Purpose: Self-checking bench for ssp_top with a slave model
// Assumes: Half tick of one clk unless a scenario slows it
// Notes:   Watchdog ends a hung run through conclude
`timescale 1ns/1ps
module tb_sync_serial_port;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              port_enable = 1'b0;
	ssp_pkg::ssp_cfg_s cfg = '{ssp_pkg::FMT_SPI, 1'b0, 1'b0, 4'h7, 8'h02, 8'h00};
	logic              tx_wr_valid = 1'b0;
	logic [15:0]       tx_wr_data = 16'h0000;
	logic              rx_rd_ready = 1'b0;
	logic              dma_tx_enable = 1'b0;
	logic              dma_rx_enable = 1'b0;
	logic [3:0]        interrupt_mask = 4'h0;
	logic              clear_timeout = 1'b0;
	logic              clear_overrun = 1'b0;
	logic              tx_wr_ready, rx_rd_valid, dma_tx_req, dma_rx_req, int_req;
	logic [15:0]       rx_rd_data;
	logic [3:0]        raw_int_status, masked_int_status;
	logic              sclk, sclk_oe_n, fss, sout, sout_oe_n, sin;
	logic [7:0]        got;
	int                n_errors = 0;
	int                n_compared = 0;
	// Design and slave
	ssp_top i_ssp_top (.*, .serial_clock_pin_o(sclk), .serial_clock_pin_oe_n(sclk_oe_n),
		.frame_select_pin(fss), .serial_out_pin_o(sout), .serial_out_pin_oe_n(sout_oe_n),
		.serial_in_pin(sin));
	ssp_slave_model i_ssp_slave_model (.clk(clk), .sclk(sclk), .fss(fss), .mosi(sout),
		.pulse(cfg.frame_format == ssp_pkg::FMT_PULSE), .reply(8'h3c), .miso(sin), .got(got));
	// 200 MHz clock
	always #2.5 clk = ~clk;
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic push_n(int n, logic [15:0] base);
		for (int i = 0; i < n; i++) begin
			tx_wr_valid <= 1'b1;
			tx_wr_data  <= base + 16'(i);
			do @(negedge clk); while (tx_wr_ready !== 1'b1);
			@(posedge clk);
		end
		tx_wr_valid <= 1'b0;
	endtask
	task automatic pop_n(int n, logic [15:0] exp);
		for (int i = 0; i < n; i++) begin
			rx_rd_ready <= 1'b1;
			do @(negedge clk); while (rx_rd_valid !== 1'b1);
			chk("rx_rd_data", rx_rd_data, exp);
			@(posedge clk);
		end
		rx_rd_ready <= 1'b0;
	endtask
	task automatic t_reset;
		repeat (2) @(negedge clk);
		chk("fss idle", 16'(fss), 16'h0001);
		chk("sclk idle", 16'(sclk), 16'h0000);
		chk("raw", 16'(raw_int_status), 16'h0001);
		chk("int_req", 16'(int_req), 16'h0000);
	endtask
	task automatic t_spi_word;
		@(posedge clk);
		port_enable <= 1'b1;
		push_n(1, 16'h00a5);
		for (int k = 0; k < 100 && rx_rd_valid !== 1'b1; k++) @(negedge clk);
		chk("mosi word", 16'(got), 16'h00a5);
		chk("sclk oe", 16'(sclk_oe_n), 16'h0000);
		repeat (40) @(negedge clk);
		chk("timeout early", 16'(raw_int_status[2]), 16'h0000);
		for (int k = 0; k < 100 && raw_int_status[2] !== 1'b1; k++) @(negedge clk);
		chk("timeout", 16'(raw_int_status[2]), 16'h0001);
		@(posedge clk);
		pop_n(1, 16'h003c);
		clear_timeout <= 1'b1;
		@(posedge clk);
		clear_timeout <= 1'b0;
		repeat (2) @(negedge clk);
		chk("timeout clear", 16'(raw_int_status[2]), 16'h0000);
	endtask
	task automatic t_mask;
		@(posedge clk);
		interrupt_mask <= 4'h1;
		repeat (3) @(negedge clk);
		chk("masked", 16'(masked_int_status), 16'h0001);
		chk("int on", 16'(int_req), 16'h0001);
		@(posedge clk);
		interrupt_mask <= 4'he;
		repeat (3) @(negedge clk);
		chk("masked off", 16'(masked_int_status), 16'h0000);
		chk("raw kept", 16'(raw_int_status), 16'h0001);
		chk("int off", 16'(int_req), 16'h0000);
	endtask
	task automatic t_fill;
		@(posedge clk);
		port_enable   <= 1'b0;
		dma_tx_enable <= 1'b1;
		push_n(8, 16'h0010);
		repeat (2) @(negedge clk);
		chk("tx full", 16'(tx_wr_ready), 16'h0000);
		chk("dma tx", 16'(dma_tx_req), 16'h0000);
		chk("tx service", 16'(raw_int_status[0]), 16'h0000);
		@(posedge clk);
		port_enable <= 1'b1;
		push_n(1, 16'h0018);
		for (int k = 0; k < 600 && raw_int_status[3] !== 1'b1; k++) @(negedge clk);
		chk("overrun", 16'(raw_int_status[3]), 16'h0001);
		chk("last word", 16'(got), 16'h0018);
		@(posedge clk);
		dma_rx_enable <= 1'b1;
		repeat (2) @(negedge clk);
		chk("dma rx", 16'(dma_rx_req), 16'h0001);
		@(posedge clk);
		pop_n(8, 16'h003c);
		repeat (2) @(negedge clk);
		chk("rx dropped", 16'(rx_rd_valid), 16'h0000);
		@(posedge clk);
		clear_overrun <= 1'b1;
		@(posedge clk);
		clear_overrun <= 1'b0;
		repeat (2) @(negedge clk);
		chk("overrun clear", 16'(raw_int_status[3]), 16'h0000);
	endtask
	task automatic t_pulse;
		@(posedge clk);
		cfg.frame_format <= ssp_pkg::FMT_PULSE;
		repeat (4) @(posedge clk);
		push_n(1, 16'h005a);
		for (int k = 0; k < 100 && rx_rd_valid !== 1'b1; k++) @(negedge clk);
		@(posedge clk);
		pop_n(1, 16'h003c);
		repeat (4) @(negedge clk);
		chk("pulse idle", {13'h0, fss, sclk, sout_oe_n}, 16'h0001);
	endtask
	task automatic t_rate;
		int n;
		n = 0;
		@(posedge clk);
		cfg <= '{ssp_pkg::FMT_SPI, 1'b1, 1'b0, 4'h7, 8'h04, 8'h01};
		repeat (12) @(negedge clk);
		chk("cpol idle", 16'(sclk), 16'h0001);
		@(posedge clk);
		push_n(1, 16'h0081);
		for (int k = 0; k < 200 && sclk !== 1'b0; k++) @(negedge clk);
		while (sclk === 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		while (sclk === 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk("serial period", 16'(n), 16'h0008);
	endtask
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_spi_word;
		t_mask;
		t_fill;
		t_pulse;
		t_rate;
		conclude;
	end
	// Watchdog
	initial begin
		#20000;
		n_errors++;
		$display("CHECK FAILED watchdog expected done seen hang");
		conclude;
	end
endmodule // tb_sync_serial_port
